// ### gpio_mode_pkg.sv
// shared constants and register layouts for the pin mode control block
package gpio_mode_pkg;

	localparam logic [7:0] PAIR_CTRL_ADDR = 8'h1B;
	localparam logic [7:0] MISC_CTRL_ADDR = 8'h1C;
	localparam logic [7:0] PAIR_CTRL_RESET = 8'h00;
	localparam logic [7:0] MISC_CTRL_RESET = 8'h00;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;
	localparam int SYNC_DEPTH_DEFAULT = 3;

	// bit 7 down to bit 0 of the pin pair control register
	typedef struct packed {
		logic pin_two_direction;
		logic pin_one_direction;
		logic pin_two_out_level;
		logic pin_one_out_level;
		logic pin_two_edge_level_sel;
		logic pin_one_edge_level_sel;
		logic pin_one_standby_ctrl;
		logic pin_one_buck_a_ctrl;
	} pair_ctrl_type;

	// bit 7 down to bit 0 of the pin three and misc control register
	typedef struct packed {
		logic pin_three_direction;
		logic pin_three_out_level;
		logic regulator_zero_enable;
		logic charge_voltage_select;
		logic spare;
		logic pin_two_irq_enable;
		logic pin_one_irq_enable;
		logic pin_two_buck_b_ctrl;
	} misc_ctrl_type;

	// commands from the register file of the rest of the chip
	typedef struct packed {
		logic buck_a_enable;
		logic buck_b_enable;
		logic standby;
	} i2c_cmd_type;

	// resolved converter controls
	typedef struct packed {
		logic buck_a_on;
		logic buck_b_on;
		logic standby;
	} buck_ctrl_type;

endpackage : gpio_mode_pkg

// ### gpio_mode_control.sv
// pin mode control: open-drain pins, pin interrupts, converter and adc control
`timescale 1ns/10ps
module gpio_mode_control
	import gpio_mode_pkg::*;
#(
	parameter int SYNC_DEPTH = SYNC_DEPTH_DEFAULT
) (
	// clock and reset
	input  wire logic         clk_sys,
	input  wire logic         sys_rst,
	// register access from the serial interface
	input  wire logic [7:0]   reg_addr,
	input  wire logic [7:0]   reg_wdata,
	input  wire logic         reg_wr,
	input  wire logic         reg_rd,
	output logic [7:0]        reg_rdata,
	// open-drain pins, index 0 is pin one
	input  wire logic [2:0]   pin_in,
	output logic [2:0]        pin_out,
	output logic [2:0]        pin_oe,
	// settings held elsewhere in the chip
	input  wire logic [1:0]   irq_mask,
	input  wire logic         uvlo,
	input  wire logic         adc_trig_sel,
	input  wire logic         adc_trig_edge,
	input  wire i2c_cmd_type  i2c_cmd,
	// results
	output logic              irq_n,
	output logic              adc_start,
	output buck_ctrl_type     buck_ctrl,
	output logic              regulator_zero_enable,
	output logic              charge_voltage_select
);

	if (SYNC_DEPTH < 3) begin : g_bad_depth
		$error("SYNC_DEPTH must be at least 3");
	end

	function automatic logic pick_edge(input logic rise, input logic fall,
		input logic fall_sel);
		pick_edge = fall_sel ? fall : rise;
	endfunction : pick_edge

	pair_ctrl_type pair_q;
	misc_ctrl_type misc_q;
	logic [2:0]    level_q;
	logic [2:0]    prev_q;
	logic [2:0]    rise;
	logic [2:0]    fall;
	logic [1:0]    flag_q;
	logic [1:0]    armed_q;
	logic [1:0]    irq_mode;
	logic [1:0]    irq_edge;
	logic [1:0]    irq_clr;
	logic [1:0]    is_input;
	logic          a_mode;
	logic          b_mode;
	logic          sby_mode;

	// pad synchronisers; only the last two stages are compared
	for (genvar p = 0; p < 3; p++) begin : g_sync
		logic [SYNC_DEPTH-1:0] sync_q;
		// pads idle high on the pull-up; a low reset would fake an edge
		always_ff @(posedge clk_sys) begin
			if (sys_rst) begin
				sync_q <= '1;
				level_q[p] <= 1'b1;
			end else begin
				sync_q <= {sync_q[SYNC_DEPTH-2:0], pin_in[p]};
				if (sync_q[SYNC_DEPTH-1] == sync_q[SYNC_DEPTH-2]) begin
					level_q[p] <= sync_q[SYNC_DEPTH-1];
				end
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			prev_q <= 3'h7;
		end else begin
			prev_q <= level_q;
		end
	end

	assign rise = level_q & ~prev_q;
	assign fall = ~level_q & prev_q;

	// register writes
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			pair_q <= PAIR_CTRL_RESET;
			misc_q <= MISC_CTRL_RESET;
		end else if (reg_wr) begin
			if (reg_addr == PAIR_CTRL_ADDR) begin
				pair_q <= reg_wdata;
			end
			if (reg_addr == MISC_CTRL_ADDR) begin
				misc_q <= reg_wdata;
			end
		end
	end

	// register reads; answer one cycle after the strobe
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			reg_rdata <= UNMAPPED_READ;
		end else if (reg_rd) begin
			case (reg_addr)
				PAIR_CTRL_ADDR: reg_rdata <= pair_q;
				MISC_CTRL_ADDR: reg_rdata <= misc_q;
				default:        reg_rdata <= UNMAPPED_READ;
			endcase
		end
	end

	// open-drain drive; the pad only ever pulls low
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			pin_out <= 3'h0;
			pin_oe  <= 3'h0;
		end else begin
			pin_out <= 3'h0;
			pin_oe[0] <= pair_q.pin_one_direction &
				~pair_q.pin_one_out_level;
			pin_oe[1] <= pair_q.pin_two_direction &
				~pair_q.pin_two_out_level;
			pin_oe[2] <= misc_q.pin_three_direction &
				~misc_q.pin_three_out_level;
		end
	end

	// input function decode; overlapping enables select no function
	assign is_input = {~pair_q.pin_two_direction, ~pair_q.pin_one_direction};
	assign irq_mode[0] = is_input[0] & misc_q.pin_one_irq_enable &
		~pair_q.pin_one_buck_a_ctrl & ~pair_q.pin_one_standby_ctrl;
	assign irq_mode[1] = is_input[1] & misc_q.pin_two_irq_enable &
		~misc_q.pin_two_buck_b_ctrl;
	assign a_mode = is_input[0] & ~misc_q.pin_one_irq_enable &
		~pair_q.pin_one_standby_ctrl & pair_q.pin_one_buck_a_ctrl;
	assign sby_mode = is_input[0] & ~misc_q.pin_one_irq_enable &
		~pair_q.pin_one_buck_a_ctrl & pair_q.pin_one_standby_ctrl;
	assign b_mode = is_input[1] & ~misc_q.pin_two_irq_enable &
		misc_q.pin_two_buck_b_ctrl;

	assign irq_edge[0] = irq_mode[0] & pick_edge(rise[0], fall[0],
		pair_q.pin_one_edge_level_sel);
	assign irq_edge[1] = irq_mode[1] & pick_edge(rise[1], fall[1],
		pair_q.pin_two_edge_level_sel);

	// release needs a second edge then a read; uvlo or output mode is at once
	assign irq_clr[0] = uvlo | ~is_input[0] |
		(armed_q[0] & reg_rd);
	assign irq_clr[1] = uvlo | ~is_input[1] |
		(armed_q[1] & reg_rd);

	for (genvar i = 0; i < 2; i++) begin : g_irq
		always_ff @(posedge clk_sys) begin
			if (sys_rst) begin
				flag_q[i]  <= 1'b0;
				armed_q[i] <= 1'b0;
			end else if (irq_edge[i] && (!flag_q[i] || irq_clr[i])) begin
				// a new edge in the clearing cycle wins over the clear
				flag_q[i]  <= 1'b1;
				armed_q[i] <= 1'b0;
			end else if (irq_clr[i]) begin
				flag_q[i]  <= 1'b0;
				armed_q[i] <= 1'b0;
			end else if (flag_q[i] && (rise[i] || fall[i])) begin
				armed_q[i] <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			irq_n <= 1'b1;
		end else begin
			irq_n <= ~|(flag_q & ~irq_mask);
		end
	end

	// adc trigger from pin three
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			adc_start <= 1'b0;
		end else begin
			adc_start <= ~misc_q.pin_three_direction & adc_trig_sel &
				pick_edge(fall[2], rise[2], adc_trig_edge);
		end
	end

	// converter gating; a pin not in a converter mode passes the command
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			buck_ctrl <= '0;
			regulator_zero_enable <= 1'b0;
			charge_voltage_select <= 1'b0;
		end else begin
			buck_ctrl.buck_a_on <= i2c_cmd.buck_a_enable & (~a_mode |
				(level_q[0] == pair_q.pin_one_edge_level_sel));
			buck_ctrl.buck_b_on <= i2c_cmd.buck_b_enable & (~b_mode |
				(level_q[1] == pair_q.pin_two_edge_level_sel));
			buck_ctrl.standby <= i2c_cmd.standby & (~sby_mode |
				(level_q[0] == pair_q.pin_one_edge_level_sel));
			regulator_zero_enable <= misc_q.regulator_zero_enable;
			charge_voltage_select <= misc_q.charge_voltage_select;
		end
	end

	// checks
	sequence s_first_edge(int k);
		irq_edge[k] && !flag_q[k] && !irq_mask[k];
	endsequence

	a_irq_assert_low: assert property (@(posedge clk_sys) disable iff (sys_rst)
		s_first_edge(0) |=> ##1 !irq_n)
		else $error("pin one edge did not pull interrupt low");
	a_irq_two_low: assert property (@(posedge clk_sys) disable iff (sys_rst)
		s_first_edge(1) |=> ##1 !irq_n)
		else $error("pin two edge did not pull interrupt low");
	a_irq_holds_unarmed: assert property (@(posedge clk_sys)
		disable iff (sys_rst)
		flag_q[0] && !armed_q[0] && !uvlo && is_input[0] |=> flag_q[0])
		else $error("pin one interrupt released without a second edge");
	a_irq_uvlo_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
		uvlo && !irq_edge[0] && !irq_edge[1] |=> flag_q == 2'b00)
		else $error("uvlo did not release pin interrupts");
	a_irq_mask_gates: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(flag_q & ~irq_mask) == 2'b00 |=> irq_n)
		else $error("masked interrupt reached the output");
	a_adc_rise_start: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!misc_q.pin_three_direction && adc_trig_sel && adc_trig_edge &&
		$rose(level_q[2]) |=> adc_start)
		else $error("rising edge on pin three did not start adc");
	a_adc_fall_start: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!misc_q.pin_three_direction && adc_trig_sel && !adc_trig_edge &&
		$fell(level_q[2]) |=> adc_start)
		else $error("falling edge on pin three did not start adc");
	a_drive_low: assert property (@(posedge clk_sys) disable iff (sys_rst)
		pair_q.pin_one_direction && !pair_q.pin_one_out_level |=>
		pin_oe[0] && !pin_out[0])
		else $error("pin one output low not driven");
	a_buck_gated: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!i2c_cmd.buck_a_enable |=> !buck_ctrl.buck_a_on)
		else $error("buck a on without register command");
	a_buck_b_pin: assert property (@(posedge clk_sys) disable iff (sys_rst)
		b_mode && i2c_cmd.buck_b_enable |=>
		buck_ctrl.buck_b_on == $past(level_q[1] ==
		pair_q.pin_two_edge_level_sel))
		else $error("buck b does not follow pin two level");
	a_reg_readback: assert property (@(posedge clk_sys) disable iff (sys_rst)
		reg_wr && reg_addr == PAIR_CTRL_ADDR ##1
		reg_rd && reg_addr == PAIR_CTRL_ADDR && !reg_wr |=>
		reg_rdata == $past(reg_wdata, 2))
		else $error("pin pair register read back differs");

endmodule : gpio_mode_control

// ### pad_model.sv
// open-drain pad model: pull-up pads with an external low driver
`timescale 1ns/10ps
module pad_model (
	// device side
	input  wire logic [2:0] pin_out,
	input  wire logic [2:0] pin_oe,
	// external driver, 0 pulls the pad low
	input  wire logic [2:0] ext_n,
	// resolved pad level back to the device
	output logic [2:0]      pin_in
);
	// wired-and: the pull-up only wins while nobody pulls low
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			pin_in[i] = (pin_oe[i] ? pin_out[i] : 1'b1) & ext_n[i];
		end
	end
endmodule : pad_model

// ### test_gpio_mode_control.sv
// self-checking bench for the pin mode control block
`timescale 1ns/10ps
module test_gpio_mode_control;
	import gpio_mode_pkg::*;
	logic          clk_sys = 1'b0;
	logic          sys_rst = 1'b1;
	logic [7:0]    reg_addr = 8'h00;
	logic [7:0]    reg_wdata = 8'h00;
	logic          reg_wr = 1'b0;
	logic          reg_rd = 1'b0;
	logic [2:0]    pad_n = 3'h7;
	logic [1:0]    irq_mask = 2'h0;
	logic          uvlo = 1'b0;
	logic          adc_trig_sel = 1'b0;
	logic          adc_trig_edge = 1'b0;
	i2c_cmd_type   i2c_cmd = '0;
	logic [7:0]    reg_rdata;
	logic [2:0]    pin_in;
	logic [2:0]    pin_out;
	logic [2:0]    pin_oe;
	logic          irq_n;
	logic          adc_start;
	logic          rz_en;
	logic          chg_sel;
	buck_ctrl_type buck_ctrl;
	int            fail_count = 0;
	int            checked = 0;
	int            seed = 11434;
	int            pulses = 0;
	logic [7:0]    v;
	logic [7:0]    d;
	logic [7:0]    r;

	always #10 clk_sys = ~clk_sys;
	// counted mid-cycle, away from the edge that launches the pulse
	always @(negedge clk_sys) if (adc_start === 1'b1) pulses++;

	gpio_mode_control #(.SYNC_DEPTH(3)) i_dut (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe(pin_oe), .irq_mask(irq_mask), .uvlo(uvlo),
		.adc_trig_sel(adc_trig_sel), .adc_trig_edge(adc_trig_edge),
		.i2c_cmd(i2c_cmd), .irq_n(irq_n), .adc_start(adc_start),
		.buck_ctrl(buck_ctrl), .regulator_zero_enable(rz_en),
		.charge_voltage_select(chg_sel));
	pad_model i_pad (.pin_out(pin_out), .pin_oe(pin_oe), .ext_n(pad_n),
		.pin_in(pin_in));

	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp

	task automatic idle(input int n);
		repeat (n) @(negedge clk_sys);
	endtask : idle

	task automatic wr(input logic [7:0] a, input logic [7:0] x);
		@(negedge clk_sys);
		reg_addr = a;
		reg_wdata = x;
		reg_wr = 1'b1;
		@(negedge clk_sys);
		reg_wr = 1'b0;
	endtask : wr

	// write then read back in the very next cycle
	task automatic wr_rd(input logic [7:0] a, input logic [7:0] x,
		output logic [7:0] y);
		@(negedge clk_sys);
		reg_addr = a;
		reg_wdata = x;
		reg_wr = 1'b1;
		@(negedge clk_sys);
		reg_wr = 1'b0;
		reg_rd = 1'b1;
		@(negedge clk_sys);
		reg_rd = 1'b0;
		y = reg_rdata;
	endtask : wr_rd

	task automatic rd(input logic [7:0] a, output logic [7:0] x);
		@(negedge clk_sys);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk_sys);
		reg_rd = 1'b0;
		@(negedge clk_sys);
		x = reg_rdata;
	endtask : rd

	// pads are held long enough for the input filter to settle
	task automatic pad(input int i, input logic lv);
		pad_n[i] = lv;
		idle(10);
	endtask : pad

	task automatic clear_irq;
		uvlo = 1'b1;
		idle(2);
		uvlo = 1'b0;
		idle(2);
	endtask : clear_irq

	function automatic logic [2:0] exp_oe(input pair_ctrl_type p,
		input misc_ctrl_type m);
		exp_oe[0] = p.pin_one_direction & ~p.pin_one_out_level;
		exp_oe[1] = p.pin_two_direction & ~p.pin_two_out_level;
		exp_oe[2] = m.pin_three_direction & ~m.pin_three_out_level;
	endfunction : exp_oe

	// mode 0 buck a, 1 buck b, 2 standby, 3 no pin function
	function automatic logic [2:0] exp_buck(input logic [1:0] m,
		input logic hit, input i2c_cmd_type c);
		exp_buck[2] = c.buck_a_enable & (m != 2'h0 | hit);
		exp_buck[1] = c.buck_b_enable & (m != 2'h1 | hit);
		exp_buck[0] = c.standby & (m != 2'h2 | hit);
	endfunction : exp_buck

	task automatic final_report;
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : final_report

	initial begin
		#1000000;
		fail_count++;
		final_report();
	end

	initial begin
		idle(16);
		sys_rst = 1'b0;
		rd(PAIR_CTRL_ADDR, v);
		cmp(v, PAIR_CTRL_RESET);
		rd(MISC_CTRL_ADDR, v);
		cmp(v, MISC_CTRL_RESET);
		for (int k = 0; k < 8; k++) begin
			d = 8'($random(seed));
			wr_rd(PAIR_CTRL_ADDR, d, v);
			cmp(v, d);
			wr(MISC_CTRL_ADDR, ~d);
			wr(8'h1D, 8'hFF);
			rd(PAIR_CTRL_ADDR, v);
			cmp(v, d);
			rd(MISC_CTRL_ADDR, v);
			cmp(v, ~d);
			cmp({6'h00, rz_en, chg_sel}, {6'h00, ~d[5:4]});
			cmp(pin_oe, exp_oe(d, ~d));
			cmp(pin_out, 3'h0);
			rd(8'h1D, v);
			cmp(v, UNMAPPED_READ);
		end
		wr(PAIR_CTRL_ADDR, 8'h00);
		wr(MISC_CTRL_ADDR, 8'h00);
		idle(10);
		clear_irq();
		cmp(irq_n, 1'b1);
		adc_trig_sel = 1'b1;
		for (int e = 0; e < 2; e++) begin
			adc_trig_edge = e[0];
			pulses = 0;
			pad(2, 1'b0);
			cmp(8'(pulses), {7'h00, ~e[0]});
			pad(2, 1'b1);
			cmp(8'(pulses), 8'h01);
		end
		adc_trig_sel = 1'b0;
		pad(2, 1'b0);
		pad(2, 1'b1);
		cmp(8'(pulses), 8'h01);
		for (int p = 0; p < 2; p++) begin
			for (int s = 0; s < 2; s++) begin
				pad(p, s[0]);
				wr(PAIR_CTRL_ADDR, {7'h00, s[0]} << (2 + p));
				wr(MISC_CTRL_ADDR, 8'h02 << p);
				pad(p, ~s[0]);
				cmp(irq_n, 1'b0);
				rd(PAIR_CTRL_ADDR, v);
				cmp(irq_n, 1'b0);
				pad(p, s[0]);
				cmp(irq_n, 1'b0);
				rd(MISC_CTRL_ADDR, v);
				idle(2);
				cmp(irq_n, 1'b1);
				irq_mask[p] = 1'b1;
				pad(p, ~s[0]);
				cmp(irq_n, 1'b1);
				wr(MISC_CTRL_ADDR, 8'h00);
				clear_irq();
				irq_mask = 2'h0;
				pad(p, 1'b1);
			end
		end
		for (int k = 0; k < 24; k++) begin
			r = 8'($random(seed));
			i2c_cmd = r[6:4];
			wr(PAIR_CTRL_ADDR, r[3:2] == 2'h0 ? {5'h00, r[0], 2'h1} :
				r[3:2] == 2'h1 ? {4'h0, r[0], 3'h0} :
				r[3:2] == 2'h2 ? {5'h00, r[0], 2'h2} : 8'h00);
			wr(MISC_CTRL_ADDR, {7'h00, r[3:2] == 2'h1});
			pad_n[1:0] = {r[1], r[1]};
			idle(10);
			cmp(buck_ctrl, exp_buck(r[3:2], r[1] == r[0], r[6:4]));
		end
		final_report();
	end
endmodule : test_gpio_mode_control
